// ==== verilog/usbhs_dev_regs.sv ====
// register file, event flags and endpoint control of the high-speed usb device
// Operation
// - eight interrupt enables, reset to zero
// - remote wake bit, hardware clears it
// - test master enable, force j or k
// - packet test uses endpoint 4, data0
// - pm busy resets one, 11-bit pm data
// - event flags set, write one clears
// - sleep flag on l1 with lpm enabled
// - transfer flag cleared via done flags
// - last transfer direction and endpoint captured
// - read-only misc link status bits
// - microframe and frame number captured
// - line levels and wake readable
// - per-direction endpoint enable masks gate transfers
// - tx toggle auto-flip, endpoint 0 manual
// - rx toggle auto-flip after good reception
// - tx burst enable and zlp mode
// - rx burst enable per endpoint
// - reply mode selects nyet or ack
// - alias maps endpoints to 9-15
// - 17-bit buffer addresses, word aligned except endpoint 0
// - dma offset limited to max length
// - received and transmit lengths recorded
// - rx done flag, write zero clears
// - tx done flag, write zero clears
`timescale 1ns/100ps
`include "usbhs_cfg.svh"
module usbhs_dev_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ev_fifo_overflow,
  input  wire logic        ev_link_ready,
  input  wire logic        ev_sof,
  input  wire logic [2:0]  sof_microframe,
  input  wire logic [10:0] sof_frame,
  input  wire logic        ev_lpm_end,
  input  wire logic [10:0] lpm_payload,
  input  wire logic        ev_l1_enter,
  input  wire logic        lpm_enable,
  input  wire logic        ev_suspend,
  input  wire logic        ev_bus_reset,
  input  wire logic        ev_xfer_end,
  input  wire logic        xfer_dir,
  input  wire logic [2:0]  xfer_ep,
  input  wire logic        xfer_ok,
  input  wire logic [15:0] xfer_count,
  input  wire logic        wake_done,
  input  wire logic        st_high_speed,
  input  wire logic        st_suspend_request,
  input  wire logic        st_engine_idle,
  input  wire logic        st_sleeping,
  input  wire logic        st_suspended,
  input  wire logic        st_link_up,
  input  wire logic        usb_dm_pin,
  input  wire logic        usb_dp_pin,
  input  wire logic        usb_wake_pin,
  input  wire logic [2:0]  dma_ep,
  input  wire logic [10:0] dma_offset,
  output logic [10:0]      dma_offset_limited,
  output logic             irq,
  output logic [6:0]       function_address,
  output logic             remote_wake_request,
  output logic             test_force_j,
  output logic             test_force_k,
  output logic             test_pkt_send,
  output logic [16:0]      test_pkt_addr,
  output logic [15:0]      test_pkt_len,
  output logic [1:0]       test_pkt_toggle,
  output logic [15:0]      ep_tx_on,
  output logic [15:0]      ep_rx_on,
  output logic [7:0]       tx_toggle,
  output logic [7:0]       rx_toggle,
  output logic [7:0]       tx_burst_on,
  output logic [7:0]       tx_burst_zlp_suppress,
  output logic [7:0]       rx_burst_on,
  output logic [7:0]       rx_nyet_select,
  output logic [7:0]       ep_high_alias
);

  usbhs_pkg::usbhs_state_t r_reg;
  usbhs_pkg::usbhs_state_t r_next;
  logic                    aw_rdy;
  logic                    w_rdy;
  logic                    ar_rdy;
  logic                    wr_fire;
  logic                    xfer_flag;
  logic [3:0]              map_idx;
  logic                    xfer_en;
  logic [10:0]             max_sel;

  // readback mux; bit 32 marks a mapped index
  function automatic logic [32:0] rd(input usbhs_pkg::usbhs_state_t s, input logic [7:0] i);
    logic [32:0] v;
    v = '0;
    case (i)
      `USBHS_IDX_IRQ_EN:   v = {1'b1, 24'h0, s.irq_en};
      `USBHS_IDX_DEV_AD:   v = {1'b1, 25'h0, s.dev_addr};
      `USBHS_IDX_WAKE:     v = {1'b1, 31'h0, s.wake};
      `USBHS_IDX_TEST:     v = {1'b1, 24'h0, s.test};
      `USBHS_IDX_PM:       v = {1'b1, 16'h0, s.pm_busy, 4'h0, s.pm_data};
      `USBHS_IDX_FLAGS:    v = {1'b1, 24'h0, s.flags[7:5], |(s.rx_done | s.tx_done), s.flags[3:0]};
      `USBHS_IDX_ISTAT:    v = {1'b1, 27'h0, s.ist_dir, 1'b0, s.ist_ep};
      `USBHS_IDX_MISC:     v = {1'b1, 24'h0, s.misc};
      `USBHS_IDX_FRAME:    v = {1'b1, 16'h0, s.frame_mf, 2'h0, s.frame_no};
      `USBHS_IDX_LINE:     v = {1'b1, 28'h0, s.dm_s2, s.dp_s2, 1'b0, s.wk_s2};
      `USBHS_IDX_TXEN:     v = {1'b1, 16'h0, s.tx_en};
      `USBHS_IDX_RXEN:     v = {1'b1, 16'h0, s.rx_en};
      `USBHS_IDX_TXAUTO:   v = {1'b1, 24'h0, s.tx_auto};
      `USBHS_IDX_RXAUTO:   v = {1'b1, 24'h0, s.rx_auto};
      `USBHS_IDX_TBURST:   v = {1'b1, 24'h0, s.tburst};
      `USBHS_IDX_TBMODE:   v = {1'b1, 24'h0, s.tbmode};
      `USBHS_IDX_RBURST:   v = {1'b1, 24'h0, s.rburst};
      `USBHS_IDX_RREPLY:   v = {1'b1, 24'h0, s.rreply};
      `USBHS_IDX_ALIAS:    v = {1'b1, 24'h0, s.alias_sel};
      `USBHS_IDX_EP0BUF:   v = {1'b1, 15'h0, s.ep0_buf};
      `USBHS_IDX_EP0MAX:   v = {1'b1, 25'h0, s.ep0_max};
      `USBHS_IDX_EP0RXLEN: v = {1'b1, 25'h0, s.ep0_rxlen};
      `USBHS_IDX_EP0TLEN:  v = {1'b1, 25'h0, s.ep0_tlen};
      `USBHS_IDX_DONE:     v = {1'b1, 16'h0, s.tx_done, s.rx_done};
      `USBHS_IDX_TOG:      v = {1'b1, 16'h0, s.rx_tog, s.tx_tog};
      default: begin
        // per-endpoint banks, four words apart
        for (int k = 0; k < 7; k++) begin
          if (i == `USBHS_IDX_RXBUF1 + (8'(k) << 2)) v = {1'b1, 15'h0, s.rx_buf[k]};
          if (i == `USBHS_IDX_TXBUF1 + (8'(k) << 2)) v = {1'b1, 15'h0, s.tx_buf[k]};
          if (i == `USBHS_IDX_MAX1 + (8'(k) << 2))   v = {1'b1, 21'h0, s.max_len[k]};
          if (i == `USBHS_IDX_RXLEN1 + (8'(k) << 2)) v = {1'b1, 16'h0, s.rx_len[k]};
          if (i == `USBHS_IDX_RSIZE1 + (8'(k) << 2)) v = {1'b1, 16'h0, s.r_size[k]};
          if (i == `USBHS_IDX_TLEN1 + (8'(k) << 2))  v = {1'b1, 16'h0, s.t_len[k]};
        end
      end
    endcase
    return v;
  endfunction : rd

  // handshakes stall while the clock enable is low
  assign aw_rdy  = ce && !r_reg.awv && !r_reg.bvalid;
  assign w_rdy   = ce && !r_reg.wv && !r_reg.bvalid;
  assign ar_rdy  = ce && !r_reg.rvalid;
  assign wr_fire = r_reg.awv && r_reg.wv && !r_reg.bvalid;

  // physical endpoint to bus endpoint number, alias picks 9-15
  assign map_idx = {r_reg.alias_sel[xfer_ep], xfer_ep};
  assign xfer_en = xfer_dir ? r_reg.tx_en[map_idx] : r_reg.rx_en[map_idx];
  assign max_sel = (dma_ep == 3'h0) ? {4'h0, r_reg.ep0_max} : r_reg.max_len[dma_ep - 3'h1];
  assign xfer_flag = |(r_reg.rx_done | r_reg.tx_done);

  // next state: bus, software writes, then hardware events so sets win
  always_comb begin
    logic [32:0] rv;
    logic [31:0] bm;
    logic [31:0] mw;
    logic [7:0]  wi;
    logic [2:0]  e1;
    rv = '0;
    bm = '0;
    mw = '0;
    wi = '0;
    e1 = '0;
    r_next = r_reg;
    if (s_axi_awvalid && aw_rdy) begin
      r_next.awv   = 1'b1;
      r_next.awidx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && w_rdy) begin
      r_next.wv    = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (s_axi_bready && r_reg.bvalid) r_next.bvalid = 1'b0;
    if (s_axi_rready && r_reg.rvalid) r_next.rvalid = 1'b0;
    if (s_axi_arvalid && ar_rdy) begin
      rv            = rd(r_reg, s_axi_araddr[9:2]);
      r_next.rvalid = 1'b1;
      r_next.rdata  = rv[31:0];
      r_next.rresp  = rv[32] ? `USBHS_RESP_OKAY : `USBHS_RESP_SLVERR;
    end
    // write once both address and data are held
    if (wr_fire) begin
      wi = r_reg.awidx;
      rv = rd(r_reg, wi);
      bm = {{8{r_reg.wstrb[3]}}, {8{r_reg.wstrb[2]}}, {8{r_reg.wstrb[1]}}, {8{r_reg.wstrb[0]}}};
      mw = (rv[31:0] & ~bm) | (r_reg.wdata & bm);
      r_next.awv    = 1'b0;
      r_next.wv     = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp  = rv[32] ? `USBHS_RESP_OKAY : `USBHS_RESP_SLVERR;
      case (wi)
        `USBHS_IDX_IRQ_EN:   r_next.irq_en = mw[7:0];
        `USBHS_IDX_DEV_AD:   r_next.dev_addr = mw[6:0];
        `USBHS_IDX_WAKE:     r_next.wake = r_reg.wake | (r_reg.wdata[0] & bm[0]);
        `USBHS_IDX_TEST:     r_next.test = mw[7:0] & `USBHS_TEST_MASK;
        `USBHS_IDX_PM:       r_next.pm_busy = mw[15];
        `USBHS_IDX_FLAGS:    r_next.flags = r_reg.flags & ~(r_reg.wdata[7:0] & bm[7:0]);
        `USBHS_IDX_TXEN:     r_next.tx_en = mw[15:0];
        `USBHS_IDX_RXEN:     r_next.rx_en = mw[15:0];
        `USBHS_IDX_TXAUTO:   r_next.tx_auto = mw[7:0] & `USBHS_AUTO_MASK;
        `USBHS_IDX_RXAUTO:   r_next.rx_auto = mw[7:0] & `USBHS_AUTO_MASK;
        `USBHS_IDX_TBURST:   r_next.tburst = mw[7:0];
        `USBHS_IDX_TBMODE:   r_next.tbmode = mw[7:0];
        `USBHS_IDX_RBURST:   r_next.rburst = mw[7:0];
        `USBHS_IDX_RREPLY:   r_next.rreply = mw[7:0];
        `USBHS_IDX_ALIAS:    r_next.alias_sel = mw[7:0] & `USBHS_ALIAS_MASK;
        `USBHS_IDX_EP0BUF:   r_next.ep0_buf = mw[16:0];
        `USBHS_IDX_EP0MAX:   r_next.ep0_max = mw[6:0];
        `USBHS_IDX_EP0RXLEN: r_next.ep0_rxlen = mw[6:0];
        `USBHS_IDX_EP0TLEN:  r_next.ep0_tlen = mw[6:0];
        `USBHS_IDX_DONE: begin
          // write zero clears, write one leaves the flag
          r_next.rx_done = r_reg.rx_done & (r_reg.wdata[7:0] | ~bm[7:0]);
          r_next.tx_done = r_reg.tx_done & (r_reg.wdata[15:8] | ~bm[15:8]);
        end
        `USBHS_IDX_TOG: begin
          r_next.tx_tog = mw[7:0];
          r_next.rx_tog = mw[15:8];
        end
        default: begin
          for (int k = 0; k < 7; k++) begin
            // low address bits forced to zero keep the buffers word aligned
            if (wi == `USBHS_IDX_RXBUF1 + (8'(k) << 2)) r_next.rx_buf[k] = {mw[16:2], 2'h0};
            if (wi == `USBHS_IDX_TXBUF1 + (8'(k) << 2)) r_next.tx_buf[k] = {mw[16:2], 2'h0};
            if (wi == `USBHS_IDX_MAX1 + (8'(k) << 2))   r_next.max_len[k] = mw[10:0];
            if (wi == `USBHS_IDX_RXLEN1 + (8'(k) << 2)) r_next.rx_len[k] = mw[15:0];
            if (wi == `USBHS_IDX_RSIZE1 + (8'(k) << 2)) r_next.r_size[k] = mw[15:0];
            if (wi == `USBHS_IDX_TLEN1 + (8'(k) << 2))  r_next.t_len[k] = mw[15:0];
          end
        end
      endcase
    end
    // wake request drops once the link has signalled it, a new write wins
    if (wake_done && !(wr_fire && r_reg.awidx == `USBHS_IDX_WAKE && r_reg.wdata[0] && r_reg.wstrb[0])) begin
      r_next.wake = 1'b0;
    end
    // event flags
    if (ev_fifo_overflow) r_next.flags[`USBHS_FB_FIFO] = 1'b1;
    if (ev_link_ready) r_next.flags[`USBHS_FB_LINK] = 1'b1;
    if (ev_sof) begin
      r_next.flags[`USBHS_FB_SOF] = 1'b1;
      r_next.frame_mf = sof_microframe;
      r_next.frame_no = sof_frame;
    end
    if (ev_lpm_end) begin
      r_next.flags[`USBHS_FB_LPM] = 1'b1;
      r_next.pm_data = lpm_payload;
    end
    if (ev_l1_enter && lpm_enable) r_next.flags[`USBHS_FB_SLEEP] = 1'b1;
    if (ev_suspend) r_next.flags[`USBHS_FB_SUSP] = 1'b1;
    if (ev_bus_reset) r_next.flags[`USBHS_FB_RST] = 1'b1;
    // transfer end, ignored for a disabled endpoint direction
    if (ev_xfer_end && xfer_en) begin
      r_next.ist_dir = xfer_dir;
      r_next.ist_ep  = xfer_ep;
      e1 = xfer_ep - 3'h1;
      if (xfer_dir) begin
        r_next.tx_done[xfer_ep] = 1'b1;
        if (xfer_ok && r_reg.tx_auto[xfer_ep]) r_next.tx_tog[xfer_ep] = ~r_next.tx_tog[xfer_ep];
      end else begin
        r_next.rx_done[xfer_ep] = 1'b1;
        if (xfer_ok && r_reg.rx_auto[xfer_ep]) r_next.rx_tog[xfer_ep] = ~r_next.rx_tog[xfer_ep];
        if (xfer_ok && xfer_ep == 3'h0) r_next.ep0_rxlen = xfer_count[6:0];
        if (xfer_ok && xfer_ep != 3'h0) begin
          r_next.rx_len[e1] = xfer_count;
          r_next.r_size[e1] = r_next.r_size[e1] + xfer_count;
        end
      end
    end
    // pin synchronisers and status capture
    r_next.dm_s1 = usb_dm_pin;
    r_next.dm_s2 = r_reg.dm_s1;
    r_next.dp_s1 = usb_dp_pin;
    r_next.dp_s2 = r_reg.dp_s1;
    r_next.wk_s1 = usb_wake_pin;
    r_next.wk_s2 = r_reg.wk_s1;
    r_next.misc = {st_high_speed, 2'h0, st_suspend_request, st_engine_idle, st_sleeping,
                   st_suspended, st_link_up};
    r_next.dma_lim = (dma_offset > max_sel) ? max_sel : dma_offset;
    if (!aresetn) begin
      r_next = '0;
      r_next.pm_busy = `USBHS_PM_BUSY_RST;
    end
  end

  // single state register, frozen by the clock enable except in reset
  always_ff @(posedge aclk) begin
    if (!aresetn || ce) begin
      r_reg <= r_next;
    end
  end

  // bus outputs
  assign s_axi_awready = aw_rdy;
  assign s_axi_wready  = w_rdy;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = ar_rdy;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;

  // interrupt request and endpoint controls toward the protocol engine
  assign irq = |({r_reg.flags[7:5], xfer_flag, r_reg.flags[3:0]} & r_reg.irq_en);
  assign function_address      = r_reg.dev_addr;
  assign remote_wake_request   = r_reg.wake;
  assign test_force_j          = r_reg.test[`USBHS_TB_EN] & r_reg.test[`USBHS_TB_J];
  assign test_force_k          = r_reg.test[`USBHS_TB_EN] & r_reg.test[`USBHS_TB_K];
  assign test_pkt_send         = r_reg.test[`USBHS_TB_EN] & (r_reg.test[`USBHS_TB_A] | r_reg.test[`USBHS_TB_B]);
  assign test_pkt_addr         = r_reg.tx_buf[`USBHS_TEST_EP_SLOT];
  assign test_pkt_len          = r_reg.t_len[`USBHS_TEST_EP_SLOT];
  assign test_pkt_toggle       = `USBHS_TEST_TOGGLE;
  assign ep_tx_on              = r_reg.tx_en;
  assign ep_rx_on              = r_reg.rx_en;
  assign tx_toggle             = r_reg.tx_tog;
  assign rx_toggle             = r_reg.rx_tog;
  assign tx_burst_on           = r_reg.tburst;
  assign tx_burst_zlp_suppress = r_reg.tbmode;
  assign rx_burst_on           = r_reg.rburst;
  assign rx_nyet_select        = r_reg.rreply;
  assign ep_high_alias         = r_reg.alias_sel;
  assign dma_offset_limited    = r_reg.dma_lim;

  // checks
  a_wake_self_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && r_reg.wake && wake_done && !wr_fire |=> !r_reg.wake)
    else $error("wake request not cleared");
  a_pm_busy_reset: assert property (@(posedge aclk)
    !aresetn |=> r_reg.pm_busy && r_reg.pm_data == 11'h0)
    else $error("pm busy not set by reset");
  a_reset_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev_bus_reset |=> r_reg.flags[`USBHS_FB_RST])
    else $error("bus reset flag missed");
  a_sleep_needs_lpm: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !r_reg.flags[`USBHS_FB_SLEEP] && !(ev_l1_enter && lpm_enable) |=> !r_reg.flags[`USBHS_FB_SLEEP])
    else $error("sleep flag set without lpm l1");
  a_xfer_flag_done: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev_xfer_end && xfer_en |=> xfer_flag ##0 r_reg.ist_ep == $past(xfer_ep))
    else $error("transfer end not flagged");
  a_dir_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev_xfer_end && xfer_en |=> r_reg.ist_dir == $past(xfer_dir))
    else $error("direction not captured");
  a_disabled_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev_xfer_end && !xfer_en && !wr_fire |=> $stable(r_reg.rx_done) && $stable(r_reg.tx_done))
    else $error("disabled endpoint flagged");
  a_ep0_tx_manual: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !wr_fire |=> $stable(r_reg.tx_tog[0]) && !r_reg.tx_auto[0])
    else $error("endpoint 0 toggle flipped by hardware");
  a_dma_clamped: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !wr_fire |=> r_reg.dma_lim <= $past(max_sel))
    else $error("dma offset over limit");
  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev_sof && r_reg.irq_en[`USBHS_FB_SOF] && !wr_fire |=> irq)
    else $error("irq missing for enabled flag");

endmodule : usbhs_dev_regs

// ==== inc/usbhs_cfg.svh ====
// register indices, field positions and reset values of the usb device register file
`ifndef USBHS_CFG_SVH
`define USBHS_CFG_SVH
// register indices, byte address is four times the index
`define USBHS_IDX_IRQ_EN   8'h02
`define USBHS_IDX_DEV_AD   8'h03
`define USBHS_IDX_WAKE     8'h04
`define USBHS_IDX_TEST     8'h05
`define USBHS_IDX_PM       8'h06
`define USBHS_IDX_FLAGS    8'h08
`define USBHS_IDX_ISTAT    8'h09
`define USBHS_IDX_MISC     8'h0a
`define USBHS_IDX_FRAME    8'h0c
`define USBHS_IDX_LINE     8'h0e
`define USBHS_IDX_TXEN     8'h10
`define USBHS_IDX_RXEN     8'h12
`define USBHS_IDX_TXAUTO   8'h14
`define USBHS_IDX_RXAUTO   8'h16
`define USBHS_IDX_TBURST   8'h18
`define USBHS_IDX_TBMODE   8'h19
`define USBHS_IDX_RBURST   8'h1a
`define USBHS_IDX_RREPLY   8'h1b
`define USBHS_IDX_ALIAS    8'h1c
`define USBHS_IDX_EP0BUF   8'h20
`define USBHS_IDX_RXBUF1   8'h24
`define USBHS_IDX_TXBUF1   8'h40
`define USBHS_IDX_EP0MAX   8'h5c
`define USBHS_IDX_MAX1     8'h60
`define USBHS_IDX_EP0RXLEN 8'h7c
`define USBHS_IDX_RXLEN1   8'h80
`define USBHS_IDX_RSIZE1   8'h82
`define USBHS_IDX_EP0TLEN  8'h9c
`define USBHS_IDX_TLEN1    8'ha0
`define USBHS_IDX_DONE     8'hc0
`define USBHS_IDX_TOG      8'hc1
// interrupt flag and enable bit positions
`define USBHS_FB_FIFO  7
`define USBHS_FB_LINK  6
`define USBHS_FB_SOF   5
`define USBHS_FB_XFER  4
`define USBHS_FB_LPM   3
`define USBHS_FB_SLEEP 2
`define USBHS_FB_SUSP  1
`define USBHS_FB_RST   0
// test control bit positions
`define USBHS_TB_EN 7
`define USBHS_TB_A  3
`define USBHS_TB_B  2
`define USBHS_TB_K  1
`define USBHS_TB_J  0
`define USBHS_TEST_EP_SLOT 3
`define USBHS_TEST_TOGGLE  2'h0
// reset value, write masks and response codes
`define USBHS_PM_BUSY_RST  1'h1
`define USBHS_ALIAS_MASK   8'hfe
`define USBHS_AUTO_MASK    8'hfe
`define USBHS_TEST_MASK    8'h8f
`define USBHS_RESP_OKAY    2'h0
`define USBHS_RESP_SLVERR  2'h2
`endif

// ==== inc/usbhs_pkg.sv ====
// state type of the usb device register file
package usbhs_pkg;
  typedef struct packed {
    logic              awv;
    logic              wv;
    logic [7:0]        awidx;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [7:0]        irq_en;
    logic [6:0]        dev_addr;
    logic              wake;
    logic [7:0]        test;
    logic              pm_busy;
    logic [10:0]       pm_data;
    logic [7:0]        flags;
    logic              ist_dir;
    logic [2:0]        ist_ep;
    logic [7:0]        misc;
    logic [2:0]        frame_mf;
    logic [10:0]       frame_no;
    logic              dm_s1;
    logic              dm_s2;
    logic              dp_s1;
    logic              dp_s2;
    logic              wk_s1;
    logic              wk_s2;
    logic [15:0]       tx_en;
    logic [15:0]       rx_en;
    logic [7:0]        tx_auto;
    logic [7:0]        rx_auto;
    logic [7:0]        tburst;
    logic [7:0]        tbmode;
    logic [7:0]        rburst;
    logic [7:0]        rreply;
    logic [7:0]        alias_sel;
    logic [16:0]       ep0_buf;
    logic [6:0][16:0]  rx_buf;
    logic [6:0][16:0]  tx_buf;
    logic [6:0]        ep0_max;
    logic [6:0][10:0]  max_len;
    logic [6:0]        ep0_rxlen;
    logic [6:0][15:0]  rx_len;
    logic [6:0][15:0]  r_size;
    logic [6:0]        ep0_tlen;
    logic [6:0][15:0]  t_len;
    logic [7:0]        rx_done;
    logic [7:0]        tx_done;
    logic [7:0]        tx_tog;
    logic [7:0]        rx_tog;
    logic [10:0]       dma_lim;
  } usbhs_state_t;
endpackage : usbhs_pkg

// ==== tb/usbhs_link_model.sv ====
// link-side event source standing in for the bus partner of the register file
`timescale 1ns/100ps
module usbhs_link_model (
  input  wire logic       aclk,
  input  wire logic [8:0] req,
  output logic            wake_done,
  output logic            ev_fifo_overflow,
  output logic            ev_link_ready,
  output logic            ev_sof,
  output logic            ev_xfer_end,
  output logic            ev_lpm_end,
  output logic            ev_l1_enter,
  output logic            ev_suspend,
  output logic            ev_bus_reset
);
  logic [8:0] q;
  // events follow req one edge later and stay high as long as req does; the bench pulses req for one cycle
  initial q = 9'h0;
  always @(posedge aclk) q <= req;
  assign {wake_done, ev_fifo_overflow, ev_link_ready, ev_sof, ev_xfer_end, ev_lpm_end, ev_l1_enter, ev_suspend,
          ev_bus_reset} = q;
endmodule : usbhs_link_model

// ==== tb/tb.sv ====
// self-checking bench for the usb device register file
`timescale 1ns/100ps
`include "usbhs_cfg.svh"
module tb;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ev_fifo_overflow;
  logic        ev_link_ready, ev_sof, ev_lpm_end, ev_l1_enter, lpm_enable, ev_suspend, ev_bus_reset, ev_xfer_end;
  logic        xfer_dir, xfer_ok, wake_done, st_high_speed, st_suspend_request, st_engine_idle, st_sleeping;
  logic        st_suspended, st_link_up, usb_dm_pin, usb_dp_pin, usb_wake_pin, irq, remote_wake_request;
  logic        test_force_j, test_force_k, test_pkt_send;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, rv;
  logic [1:0]  s_axi_bresp, s_axi_rresp, test_pkt_toggle;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  sof_microframe, xfer_ep, dma_ep;
  logic [10:0] sof_frame, lpm_payload, dma_offset, dma_offset_limited;
  logic [15:0] xfer_count, test_pkt_len, ep_tx_on, ep_rx_on;
  logic [6:0]  function_address;
  logic [16:0] test_pkt_addr;
  logic [7:0]  tx_toggle, rx_toggle, tx_burst_on, tx_burst_zlp_suppress, rx_burst_on, rx_nyet_select, ep_high_alias;
  logic [8:0]  req;
  logic [33:0] exp_q[$];
  int          bad_count = 0, total_checks = 0;
  usbhs_dev_regs   DUT (.*);
  usbhs_link_model link (.*);
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r = `USBHS_RESP_OKAY);
    exp_q.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic ev(input logic [8:0] r);
    @(posedge aclk);
    req <= r;
    @(posedge aclk);
    req <= 9'h0;
    // the model delays the pulse one edge and the flag lands one edge later
    repeat (2) @(posedge aclk);
  endtask : ev
  // scoreboard: each read answer against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    finish_test;
  end
  initial begin
    seed = 32'h08dd75d8;
    {ce, s_axi_wstrb, xfer_ok, dma_ep, req, s_axi_awvalid, s_axi_wvalid} = {1'h1, 4'hf, 1'h1, 3'h4, 11'h0};
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 99'h0;
    {st_high_speed, st_suspend_request, st_engine_idle, st_sleeping, st_suspended, st_link_up, usb_dm_pin,
     usb_dp_pin, usb_wake_pin, dma_offset} = 20'($random(seed));
    {lpm_enable, xfer_dir, xfer_ep, xfer_count, sof_microframe, sof_frame} = {5'h11, 16'h0040, 3'h5, 11'h2a5};
    lpm_payload = 11'($random(seed));
    aresetn = 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`USBHS_IDX_IRQ_EN, 32'h0);
    rd(`USBHS_IDX_PM, 32'h8000);
    rd(8'h01, 32'h0, `USBHS_RESP_SLVERR);
    rd(`USBHS_IDX_MISC, {24'h0, st_high_speed, 2'h0, st_suspend_request, st_engine_idle, st_sleeping, st_suspended,
       st_link_up});
    rd(`USBHS_IDX_LINE, {28'h0, usb_dm_pin, usb_dp_pin, 1'h0, usb_wake_pin});
    wr(`USBHS_IDX_IRQ_EN, 32'hff);
    rd(`USBHS_IDX_IRQ_EN, 32'hff);
    // each write-one-clear flag: set by its event, deaf to zero, cleared by its own one
    for (int b = 0; b < 8; b++) if (b != 4) begin
      ev(9'(1 << b));
      chk("irq", 34'h1, 34'(irq));
      wr(`USBHS_IDX_FLAGS, 32'h0);
      rd(`USBHS_IDX_FLAGS, 32'(1 << b));
      wr(`USBHS_IDX_FLAGS, 32'(1 << b));
      rd(`USBHS_IDX_FLAGS, 32'h0);
    end
    rd(`USBHS_IDX_FRAME, 32'ha2a5);
    rd(`USBHS_IDX_PM, {16'h0, 5'h10, lpm_payload});
    $display("test flags done");
    wr(`USBHS_IDX_RXEN, 32'h2);
    ev(9'h10);
    rd(`USBHS_IDX_FLAGS, 32'h10);
    rd(`USBHS_IDX_ISTAT, 32'h1);
    rd(`USBHS_IDX_RSIZE1, 32'h40);
    wr(`USBHS_IDX_DONE, 32'h0);
    xfer_ep <= 3'h2;
    rd(`USBHS_IDX_FLAGS, 32'h0);
    ev(9'h10);
    rd(`USBHS_IDX_FLAGS, 32'h0);
    $display("test transfer done");
    wr(`USBHS_IDX_WAKE, 32'h1);
    chk("wake", 34'h1, 34'(remote_wake_request));
    ev(9'h100);
    rd(`USBHS_IDX_WAKE, 32'h0);
    wr(`USBHS_IDX_TEST, 32'h82);
    chk("force_k", 34'h2, 34'({test_force_k, test_force_j}));
    wr(`USBHS_IDX_ALIAS, 32'hff);
    rd(`USBHS_IDX_ALIAS, 32'hfe);
    // packet test reads endpoint 4 buffer and length, low address bits dropped
    wr(`USBHS_IDX_TXBUF1 + 8'h0c, 32'h12347);
    wr(`USBHS_IDX_TLEN1 + 8'h0c, 32'h0123);
    wr(`USBHS_IDX_TEST, 32'h88);
    chk("test_pkt", {1'h1, 17'h12344, 16'h0123}, {test_pkt_send, test_pkt_addr, test_pkt_len});
    chk("pkt_toggle", 34'h0, 34'(test_pkt_toggle));
    // dma offset clamp for endpoint 4, one extra edge for the registered result
    wr(`USBHS_IDX_MAX1 + 8'h0c, 32'h100);
    @(posedge aclk);
    chk("dma_lim", 34'((dma_offset > 11'h100) ? 11'h100 : dma_offset), 34'(dma_offset_limited));
    rv = $random(seed);
    wr(`USBHS_IDX_TXEN, rv);
    rd(`USBHS_IDX_TXEN, {16'h0, rv[15:0]});
    $display("test control done");
    finish_test;
  end
endmodule : tb
